// ===== common/fmwg_pkg.sv
package fmwg_pkg;

    // ---------------------------------------------------------------
    // peripheral register offsets
    // ---------------------------------------------------------------
    localparam logic [15:0] CMD_ADDR = 16'hFFC0;
    localparam logic [15:0] STAT_ADDR = 16'hFFC2;
    localparam logic [15:0] MODE_ADDR = 16'hFFC4;

    // ---------------------------------------------------------------
    // values and fields
    // ---------------------------------------------------------------
    localparam logic [7:0] UNLOCK_KEY = 8'hA5;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] MODE_RST_USER = 8'h08;
    localparam logic [7:0] MODE_RST_BOARD = 8'h0C;
    localparam int ERR_BIT = 0;
    localparam int SPM_LO_BIT = 0;
    localparam int SPM_HI_BIT = 1;
    localparam int PIN_BIT = 2;
    localparam int WED_BIT = 3;
    localparam logic [7:0] MODE_WR_MASK = 8'h0B;

    // ---------------------------------------------------------------
    // self-programming modes and boot area
    // ---------------------------------------------------------------
    localparam logic [1:0] SPM_NORMAL = 2'h0;
    localparam logic [1:0] SPM_A1 = 2'h1;
    localparam logic [1:0] SPM_BAD = 2'h2;
    localparam logic [1:0] SPM_A2 = 2'h3;
    localparam int CLUSTER_BIT = 12;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_KEY,
        SEQ_VAL,
        SEQ_INV
    } fmwg_seq_type;

endpackage

// ===== rtl/fmwg_boot_map.sv
`timescale 1ns/1ns
// swaps boot cluster 0 and 1 when the swap latch is set
module fmwg_boot_map #(
    parameter int AW = 16
) (
    // address
    input wire logic [AW-1:0] addr_i,
    input wire logic swap_i,
    output logic [AW-1:0] addr_o
);
    wire logic in_boot;
    assign in_boot = (addr_i[AW-1:fmwg_pkg::CLUSTER_BIT+1] == '0);
    always_comb
    begin
        addr_o = addr_i;
        if (swap_i && in_boot)
        begin
            addr_o[fmwg_pkg::CLUSTER_BIT] = ~addr_i[fmwg_pkg::CLUSTER_BIT]; // R19
        end
    end
endmodule

// ===== rtl/fmwg_top.sv
`timescale 1ns/1ns
// Contract
// R1: mode register changes only on fourth store of A5H, value, inverse, value.
// R2: second and third stores never change the mode register.
// R3: software repeats the whole sequence for every change.
// R4: broken sequence leaves mode register unwritten and sets error flag bit 0.
// R5: command write not preceded by key write to command sets error.
// R6: store to other register right after steps one to three sets error.
// R7: third store not exact inverse of second sets error.
// R8: fourth store not equal to second sets error and skips update.
// R9: error flag is sticky; software clears by writing 0, hardware only sets.
// R10: reset clears status to 00H; upper seven bits read zero.
// R11: command register is write only and not initialised.
// R12: software writes command register byte-wide only.
// R13: status register accepts bit and byte accesses.
// R14: software keeps write disable at 0 until write or erase completes.
// R15: software keeps write disable at 1 in normal mode.
// R16: software changes mode bits only while executing from RAM.
// R17: flash address from CPU when mode hi is 0, firmware when 1.
// R18: on-board mode ignores both self-programming mode bits.
// R19: boot swap exchanges 4 KB boot clusters 0 and 1.
// R20: boot swap takes effect at next reset after boot flag set.
// R21: write or erase enabled only with disable 0 and pin level 1.
// R22: mode codes: 00 normal, 01 A1, 11 A2, 10 prohibited.
// R23: reset value 08H user, 0CH on-board; pin level bit read only.
// R24: checker keeps second value and returns idle after end or error.
// R25: unrelated stores while idle affect neither sequence nor flag.
module fmwg_top #(
    parameter int AW = 16
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // peripheral store and load port
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] bit_mask_i,
    output logic [7:0] rdata_o,
    // pins and straps
    input wire logic flash_mode_pin_i,
    input wire logic onboard_mode_i,
    input wire logic boot_flag_i,
    // flash control
    input wire logic [AW-1:0] cpu_addr_i,
    input wire logic [AW-1:0] fw_addr_i,
    output logic [AW-1:0] flash_addr_o,
    output logic write_erase_en_o,
    output logic [1:0] self_prog_mode_o,
    output logic boot_swap_o
);

    // ---------------------------------------------------------------
    // pin synchronisers and reset-time capture
    // ---------------------------------------------------------------
    logic pin_meta_r, pin_r, board_meta_r, board_r, flag_meta_r, flag_r;
    logic start_r, swap_r;
    // no reset here: the straps must already be through both flops at the first edge after release
    always_ff @(posedge clk_sys_i)
    begin
        pin_meta_r <= flash_mode_pin_i;
        pin_r <= pin_meta_r;
        board_meta_r <= onboard_mode_i;
        board_r <= board_meta_r;
        flag_meta_r <= boot_flag_i;
        flag_r <= flag_meta_r;
    end

    // ---------------------------------------------------------------
    // store decode
    // ---------------------------------------------------------------
    wire logic wr_cmd = wr_i && (addr_i == fmwg_pkg::CMD_ADDR);
    wire logic wr_stat = wr_i && (addr_i == fmwg_pkg::STAT_ADDR);
    wire logic wr_mode = wr_i && (addr_i == fmwg_pkg::MODE_ADDR);
    wire logic wr_key = wr_cmd && (wdata_i == fmwg_pkg::UNLOCK_KEY);

    // ---------------------------------------------------------------
    // unlock sequence checker
    // ---------------------------------------------------------------
    fmwg_pkg::fmwg_seq_type seq_r, seq_nxt;
    logic [7:0] val_r, val_nxt;
    logic last_key_r;
    logic [7:0] mode_r, mode_nxt;
    logic err_r, err_nxt;
    logic seq_err, mode_load;
    logic [7:0] mode_wval;

    // a bit store writes only the lanes in bit_mask_i, the rest keep their value
    assign mode_wval = (wdata_i & bit_mask_i) | (mode_r & ~bit_mask_i);

    always_comb
    begin
        seq_nxt = seq_r;
        val_nxt = val_r;
        seq_err = 1'b0;
        mode_load = 1'b0;
        if (wr_cmd && !wr_key && !last_key_r)
        begin
            seq_err = 1'b1; // R5
        end
        case (seq_r)
            fmwg_pkg::SEQ_IDLE:
            begin
                if (wr_mode)
                begin
                    seq_err = 1'b1; // R4
                end
                // stores to registers other than mode, command or status leave checker and flag alone
                if (wr_key && !seq_err)
                begin
                    seq_nxt = fmwg_pkg::SEQ_KEY; // R25
                end
            end
            fmwg_pkg::SEQ_KEY:
            begin
                if (wr_i)
                begin
                    if (wr_mode)
                    begin
                        val_nxt = mode_wval; // R24
                        seq_nxt = fmwg_pkg::SEQ_VAL; // R2
                    end
                    else
                    begin
                        seq_err = 1'b1; // R6
                    end
                end
            end
            fmwg_pkg::SEQ_VAL:
            begin
                if (wr_i)
                begin
                    if (wr_mode && (mode_wval == ~val_r))
                    begin
                        seq_nxt = fmwg_pkg::SEQ_INV; // R2
                    end
                    else
                    begin
                        seq_err = 1'b1; // R7
                    end
                end
            end
            fmwg_pkg::SEQ_INV:
            begin
                if (wr_i)
                begin
                    if (wr_mode && (mode_wval == val_r))
                    begin
                        mode_load = 1'b1; // R1
                    end
                    else
                    begin
                        seq_err = 1'b1; // R8
                    end
                    seq_nxt = fmwg_pkg::SEQ_IDLE; // R3
                end
            end
            default:
            begin
                seq_nxt = fmwg_pkg::SEQ_IDLE;
            end
        endcase
        if (seq_err)
        begin
            seq_nxt = fmwg_pkg::SEQ_IDLE; // R24
        end
    end

    // ---------------------------------------------------------------
    // mode register and error flag next values
    // ---------------------------------------------------------------
    always_comb
    begin
        mode_nxt = mode_r;
        if (mode_load)
        begin
            mode_nxt = val_r & fmwg_pkg::MODE_WR_MASK;
        end
        mode_nxt[fmwg_pkg::PIN_BIT] = pin_r; // R23
        err_nxt = err_r;
        if (wr_stat && bit_mask_i[fmwg_pkg::ERR_BIT] && !wdata_i[fmwg_pkg::ERR_BIT])
        begin
            err_nxt = 1'b0; // R13
        end
        if (seq_err)
        begin
            err_nxt = 1'b1; // R9
        end
    end

    // ---------------------------------------------------------------
    // state registers
    // ---------------------------------------------------------------
    // the command register itself is never stored: only whether the last store was the key matters
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            seq_r <= fmwg_pkg::SEQ_IDLE;
            val_r <= fmwg_pkg::STAT_RESET;
            last_key_r <= 1'b0;
            err_r <= 1'b0; // R10
        end
        else
        begin
            seq_r <= seq_nxt;
            val_r <= val_nxt;
            err_r <= err_nxt;
            if (wr_i)
            begin
                last_key_r <= wr_key; // R11
            end
        end
    end

    // reset value depends on a strap, so it is loaded on the first edge after release
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            start_r <= 1'b1;
            mode_r <= fmwg_pkg::MODE_RST_USER;
            swap_r <= 1'b0;
        end
        else if (start_r)
        begin
            start_r <= 1'b0;
            mode_r <= board_r ? fmwg_pkg::MODE_RST_BOARD : fmwg_pkg::MODE_RST_USER; // R23
            swap_r <= flag_r; // R20
        end
        else
        begin
            mode_r <= mode_nxt;
        end
    end

    // ---------------------------------------------------------------
    // read port and flash controls
    // ---------------------------------------------------------------
    wire logic [1:0] spm = board_r ? fmwg_pkg::SPM_NORMAL
                                   : mode_r[fmwg_pkg::SPM_HI_BIT:fmwg_pkg::SPM_LO_BIT]; // R18
    wire logic we_en = !mode_r[fmwg_pkg::WED_BIT] && pin_r; // R21
    wire logic [AW-1:0] src_addr = spm[1] ? fw_addr_i : cpu_addr_i; // R17
    logic [AW-1:0] map_addr;
    wire logic [7:0] stat_val = {7'h00, err_r}; // R10
    wire logic [7:0] rd_val = (addr_i == fmwg_pkg::STAT_ADDR) ? stat_val
                            : (addr_i == fmwg_pkg::MODE_ADDR) ? mode_r : 8'h00;

    fmwg_boot_map #(
        .AW(AW)
    ) u_map (
        .addr_i(src_addr),
        .swap_i(swap_r),
        .addr_o(map_addr)
    );

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rdata_o <= 8'h00;
            flash_addr_o <= '0;
            write_erase_en_o <= 1'b0;
            self_prog_mode_o <= fmwg_pkg::SPM_NORMAL;
            boot_swap_o <= 1'b0;
        end
        else
        begin
            rdata_o <= rd_i ? rd_val : 8'h00;
            flash_addr_o <= map_addr; // R19
            write_erase_en_o <= we_en;
            self_prog_mode_o <= spm; // R22
            boot_swap_o <= swap_r;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    // writable mode bits move only on the store that completes a sequence
    seq_no_write_a: assert property (!mode_load && !start_r // R2
        |=> $stable(mode_r[fmwg_pkg::SPM_HI_BIT:fmwg_pkg::SPM_LO_BIT]) && $stable(mode_r[fmwg_pkg::WED_BIT]))
        else $error("mode changed outside fourth store");
    full_unlock_a: assert property (wr_key && seq_r == fmwg_pkg::SEQ_IDLE ##1 !wr_i ##1 // R1
        (wr_mode && wdata_i == 8'h01 && bit_mask_i == 8'hFF) ##1 !wr_i ##1
        (wr_mode && wdata_i == 8'hFE && bit_mask_i == 8'hFF) ##1 !wr_i ##1
        (wr_mode && wdata_i == 8'h01 && bit_mask_i == 8'hFF) |=> mode_r[1:0] == 2'h1)
        else $error("valid sequence did not update mode");
    bad_inv_a: assert property (seq_r == fmwg_pkg::SEQ_VAL && wr_mode && mode_wval != ~val_r // R7
        |=> err_r && seq_r == fmwg_pkg::SEQ_IDLE)
        else $error("bad inverse not flagged");
    bad_final_a: assert property (seq_r == fmwg_pkg::SEQ_INV && wr_mode && mode_wval != val_r // R8
        |=> err_r && $stable(mode_r[1:0]))
        else $error("bad final value not flagged");
    wrong_reg_a: assert property (seq_r != fmwg_pkg::SEQ_IDLE && wr_i && !wr_mode |=> err_r) // R6
        else $error("store to other register not flagged");
    cmd_order_a: assert property (wr_cmd && !wr_key && !last_key_r |=> err_r) // R5
        else $error("command write not flagged");
    err_sticky_a: assert property (err_r && !wr_stat |=> err_r) // R9
        else $error("error flag dropped");
    stat_high_a: assert property (rd_i && addr_i == fmwg_pkg::STAT_ADDR |=> rdata_o[7:1] == 7'h00) // R10
        else $error("status upper bits not zero");
    we_gate_a: assert property (##1 write_erase_en_o == $past(we_en)) // R21
        else $error("write enable mismatch");
    idle_quiet_a: assert property (seq_r == fmwg_pkg::SEQ_IDLE && wr_i && !wr_cmd && !wr_mode && !wr_stat // R25
        |=> $stable(err_r) && seq_r == fmwg_pkg::SEQ_IDLE)
        else $error("unrelated store disturbed checker");

    cover_unlock_c: cover property (mode_load);
    cover_err_c: cover property (seq_err);
    cover_clear_c: cover property (err_r ##1 !err_r);
    cover_swap_c: cover property (swap_r);

endmodule

// ===== tb/fmwg_cpu_model.sv
`timescale 1ns/1ns
// cpu side: issues peripheral stores and loads one at a time
module fmwg_cpu_model (
    // clock
    input wire logic clk_sys_i,
    // peripheral bus
    output logic wr_o,
    output logic rd_o,
    output logic [15:0] addr_o,
    output logic [7:0] wdata_o,
    output logic [7:0] bit_mask_o,
    input wire logic [7:0] rdata_i
);
    initial
    begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 16'h0000;
        wdata_o = 8'h00;
        bit_mask_o = 8'h00;
    end

    // released address and data lines show the inverse so a stale value cannot pass for a live one
    task automatic store(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
        @(posedge clk_sys_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        bit_mask_o <= m;
        @(posedge clk_sys_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask

    task automatic load(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_sys_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask

    // the whole sequence is sent for every change; an unlock is never reused
    // callers run from ram here and never pick normal mode with writes enabled
    task automatic unlock(input logic [7:0] v);
        store(fmwg_pkg::CMD_ADDR, fmwg_pkg::UNLOCK_KEY, 8'hFF);
        store(fmwg_pkg::MODE_ADDR, v, 8'hFF);
        store(fmwg_pkg::MODE_ADDR, ~v, 8'hFF);
        store(fmwg_pkg::MODE_ADDR, v, 8'hFF);
    endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic wr, rd;
    logic [15:0] addr;
    logic [7:0] wdata, mask, rdata, rv;
    logic pin = 1'b1;
    logic onboard = 1'b0;
    logic bflag = 1'b0;
    logic [15:0] cpu_a = 16'h4321;
    logic [15:0] fw_a = 16'h8765;
    logic [15:0] faddr;
    logic we_en, swap;
    logic [1:0] spm;
    int n_mismatch = 0;
    int n_tests = 0;

    always #5 clk_sys_i = ~clk_sys_i;

    fmwg_cpu_model u_cpu (.clk_sys_i(clk_sys_i), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata),
        .bit_mask_o(mask), .rdata_i(rdata));

    fmwg_top dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .wr_i(wr), .rd_i(rd), .addr_i(addr),
        .wdata_i(wdata), .bit_mask_i(mask), .rdata_o(rdata), .flash_mode_pin_i(pin),
        .onboard_mode_i(onboard), .boot_flag_i(bflag), .cpu_addr_i(cpu_a), .fw_addr_i(fw_a),
        .flash_addr_o(faddr), .write_erase_en_o(we_en), .self_prog_mode_o(spm), .boot_swap_o(swap));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic test_done();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // straps pass free-running sync flops, so they are settled when reset lets go
    task automatic do_reset();
        @(posedge clk_sys_i);
        rstn_i <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic read_chk(input logic [15:0] a, input logic [7:0] e);
        u_cpu.load(a, rv);
        `CHK(rv, e)
    endtask

    // checks the status byte, then clears the flag for the next case
    task automatic flag_chk(input logic [7:0] e);
        read_chk(fmwg_pkg::STAT_ADDR, e);
        u_cpu.store(fmwg_pkg::STAT_ADDR, 8'h00, 8'hFF);
    endtask

    // n good steps (key, 08H, F7H) then one wrong store; mode must keep A1
    task automatic bad_seq(input int n, input logic [15:0] a, input logic [7:0] d);
        u_cpu.store(fmwg_pkg::CMD_ADDR, fmwg_pkg::UNLOCK_KEY, 8'hFF);
        if (n > 1)
            u_cpu.store(fmwg_pkg::MODE_ADDR, 8'h08, 8'hFF);
        if (n > 2)
            u_cpu.store(fmwg_pkg::MODE_ADDR, 8'hF7, 8'hFF);
        u_cpu.store(a, d, 8'hFF);
        settle();
        `CHK(spm, fmwg_pkg::SPM_A1)
        flag_chk(8'h01);
    endtask

    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial
    begin
        do_reset();
        read_chk(fmwg_pkg::STAT_ADDR, 8'h00);
        read_chk(fmwg_pkg::MODE_ADDR, 8'h0C);
        read_chk(fmwg_pkg::CMD_ADDR, 8'h00);
        `CHK(we_en, 1'b0)
        u_cpu.store(fmwg_pkg::MODE_ADDR, 8'h01, 8'hFF);
        u_cpu.store(fmwg_pkg::MODE_ADDR, 8'h01, 8'hFF);
        settle();
        `CHK(spm, fmwg_pkg::SPM_NORMAL)
        read_chk(fmwg_pkg::STAT_ADDR, 8'h01);
        u_cpu.store(fmwg_pkg::STAT_ADDR, 8'hFE, 8'h01);
        read_chk(fmwg_pkg::STAT_ADDR, 8'h00);
        u_cpu.store(16'hFF00, 8'h55, 8'hFF);
        read_chk(fmwg_pkg::STAT_ADDR, 8'h00);
        u_cpu.store(fmwg_pkg::CMD_ADDR, 8'h3C, 8'hFF);
        flag_chk(8'h01);
        u_cpu.store(fmwg_pkg::CMD_ADDR, fmwg_pkg::UNLOCK_KEY, 8'hFF);
        u_cpu.store(fmwg_pkg::MODE_ADDR, 8'h01, 8'hFF);
        settle();
        `CHK(spm, fmwg_pkg::SPM_NORMAL)
        u_cpu.store(fmwg_pkg::MODE_ADDR, 8'hFE, 8'hFF);
        settle();
        `CHK(spm, fmwg_pkg::SPM_NORMAL)
        u_cpu.store(fmwg_pkg::MODE_ADDR, 8'h01, 8'hFF);
        settle();
        `CHK(spm, fmwg_pkg::SPM_A1)
        `CHK(we_en, 1'b1)
        `CHK(faddr, cpu_a)
        read_chk(fmwg_pkg::MODE_ADDR, 8'h05);
        flag_chk(8'h00);
        @(posedge clk_sys_i);
        pin <= 1'b0;
        settle();
        settle();
        `CHK(we_en, 1'b0)
        read_chk(fmwg_pkg::MODE_ADDR, 8'h01);
        @(posedge clk_sys_i);
        pin <= 1'b1;
        bad_seq(1, 16'hFF00, 8'h08);
        bad_seq(2, 16'hFF00, 8'hF7);
        bad_seq(3, 16'hFF00, 8'h08);
        bad_seq(2, fmwg_pkg::MODE_ADDR, 8'h00);
        bad_seq(3, fmwg_pkg::MODE_ADDR, 8'h09);
        u_cpu.unlock(8'h03);
        settle();
        `CHK(spm, fmwg_pkg::SPM_A2)
        `CHK(faddr, fw_a)
        flag_chk(8'h00);
        u_cpu.store(fmwg_pkg::MODE_ADDR, 8'h08, 8'hFF);
        settle();
        `CHK(spm, fmwg_pkg::SPM_A2)
        flag_chk(8'h01);
        // boot flag raised in mid-run must wait for the next reset
        @(posedge clk_sys_i);
        bflag <= 1'b1;
        onboard <= 1'b1;
        cpu_a <= 16'h0123;
        settle();
        `CHK(swap, 1'b0)
        do_reset();
        settle();
        `CHK(swap, 1'b1)
        `CHK(faddr, 16'h1123)
        u_cpu.unlock(8'h01);
        settle();
        `CHK(spm, fmwg_pkg::SPM_NORMAL)
        read_chk(fmwg_pkg::MODE_ADDR, 8'h05);
        test_done();
    end

    initial
    begin
        repeat (3000) @(posedge clk_sys_i);
        n_mismatch++;
        test_done();
    end
endmodule
